// *** scfg_host.sv ***
`timescale 1ns/1ns
`default_nettype none
module scfg_host (
  // Bench clock.
  input wire logic clk,
  // Serial pins, data is open drain with a pull-up.
  input wire logic sda,
  output logic scl,
  output logic sda_low
);
  ////////////////////////////////////////
  // Bus starts idle: clock high, data released.
  initial
  begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  // Half of the 160 ns serial clock period.
  task automatic half;
    repeat (4) @(negedge clk);
  endtask

  // Start or repeated start: data falls while the clock is high.
  task automatic start;
    half;
    sda_low = 1'b0;
    half;
    scl = 1'b1;
    half;
    sda_low = 1'b1;
    half;
    scl = 1'b0;
  endtask

  // Stop: data rises while the clock is high, leaving the bus idle.
  task automatic stop;
    half;
    sda_low = 1'b1;
    half;
    scl = 1'b1;
    half;
    sda_low = 1'b0;
    half;
  endtask

  // One bit; data moves mid-low so it never changes while the clock is high.
  task automatic bit_io(input logic b, output logic seen);
    repeat (2) @(negedge clk);
    sda_low = ~b;
    repeat (2) @(negedge clk);
    scl = 1'b1;
    half;
    seen = sda;
    scl = 1'b0;
  endtask

  // Eight bits MSB first, then the ninth bit released (a not-acknowledge on reads).
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx, output logic ack);
    for (int i = 7; i >= 0; i--)
      bit_io(tx[i], rx[i]);
    bit_io(1'b1, ack);
  endtask
endmodule
`default_nettype wire

// *** scfg_pkg.sv ***
package scfg_pkg;
  // Register offsets.
  localparam logic [7:0] OFS_OBSERVE = 8'h00;
  localparam logic [7:0] OFS_PWDN = 8'h01;
  localparam logic [7:0] OFS_RST_OVR = 8'h02;
  localparam logic [7:0] OFS_CHECK = 8'h05;
  localparam logic [7:0] OFS_ACCESS = 8'h06;
  localparam logic [7:0] OFS_SOFT_RST = 8'h07;
  localparam logic [7:0] OFS_PIN_OVR = 8'h08;
  // Reset values.
  localparam logic [7:0] DEF_OBSERVE = 8'h00;
  localparam logic [7:0] DEF_PWDN = 8'h00;
  localparam logic [7:0] DEF_RST_OVR = 8'h00;
  localparam logic [7:0] DEF_CHECK = 8'h00;
  localparam logic [7:0] DEF_ACCESS = 8'h10;
  localparam logic [7:0] DEF_SOFT_RST = 8'h01;
  localparam logic [7:0] DEF_PIN_OVR = 8'h00;
  // Field positions and masks.
  localparam int BIT_RST_OVR = 0;
  localparam int BIT_NO_CHECK = 3;
  localparam int BIT_REG_RESET = 6;
  localparam int BIT_MST_RESET = 5;
  localparam int BIT_RECEIVER_DETECT_OVR = 3;
  localparam int BIT_MODE_OVR = 2;
  localparam logic [7:0] MASK_OBSERVE_RW = 8'h83;
  localparam logic [7:0] MASK_SOFT_RST_RW = 8'h9F;
  localparam logic [7:0] ALL_POWERED_DOWN = 8'hFF;
  // Seven-bit slave address for strap value zero.
  localparam logic [6:0] SLAVE_ADDR_BASE = 7'h58;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  // Slave protocol states.
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0000,
    ST_ADDR = 4'b0001,
    ST_ACK_ADDR = 4'b0010,
    ST_INDEX = 4'b0011,
    ST_ACK_INDEX = 4'b0100,
    ST_WDATA = 4'b0101,
    ST_ACK_WDATA = 4'b0110,
    ST_RDATA = 4'b0111,
    ST_MACK = 4'b1000
  } scfg_state_e;
endpackage

// *** scfg_regs.sv ***
// Behaviour
// - Device acknowledges low after an address byte matching its own.
// - Host sends a register index; device acknowledges it low.
// - Device shifts out the eight bits of the indexed register.
// - Observation bits 6:3 show live strap levels, strap 3 in bit 6.
// - Observation bit 2 reads one once configuration load has finished.
// - Each power-down bit disables a channel; all ones means low power.
// - Override bit set: reset pin ignored, power-down from register.
// - No-check bit set lets channel writes pass without check byte match.
// - Writing register-reset bit restores all register defaults; it self-clears.
// - Writing master-reset bit resets the master state machine; self-clears.
// - Receiver-detect override bit takes receiver detect from registers.
// - Mode override bit takes operating mode from registers.
// - Address byte is B0h plus twice the strap value.
`timescale 1ns/1ns
`default_nettype none
module scfg_regs
  import scfg_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Serial port pins, open drain data.
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // Device pins and internal status.
  input wire logic [3:0] strap_addr,
  input wire logic reset_pin_n,
  input wire logic mode_pin,
  input wire logic receiver_detect_pin,
  input wire logic config_load_done,
  input wire logic [7:0] check_expected,
  input wire logic mode_reg_value,
  input wire logic receiver_detect_reg_value,
  // Control results.
  output logic [7:0] chan_power_down,
  output logic low_power,
  output logic channel_write_ok,
  output logic mode_sel,
  output logic receiver_detect_sel,
  output logic master_reset
);

  typedef struct packed {
    logic scl1, scl2, scl3, sda1, sda2, sda3;
    logic [6:0] pin1, pin2;
    scfg_state_e state;
    logic [3:0] cnt;
    logic [7:0] sh, index;
    logic rw, mack, sda_oe, sda_out;
    logic [7:0] obs, pwdn, rst_ovr, check, access, soft_rst, pin_ovr;
    logic [7:0] chan_power_down;
    logic low_power, channel_write_ok, mode_sel, receiver_detect_sel, master_reset;
  } scfg_state_s;

  localparam scfg_state_s RESET_STATE = '{
    scl1: 1'b1, scl2: 1'b1, scl3: 1'b1, sda1: 1'b1, sda2: 1'b1, sda3: 1'b1,
    pin1: 7'h00, pin2: 7'h00, state: ST_IDLE, cnt: 4'h0, sh: 8'h00, index: 8'h00,
    rw: 1'b0, mack: 1'b0, sda_oe: 1'b0, sda_out: 1'b0,
    obs: DEF_OBSERVE, pwdn: DEF_PWDN, rst_ovr: DEF_RST_OVR, check: DEF_CHECK,
    access: DEF_ACCESS, soft_rst: DEF_SOFT_RST, pin_ovr: DEF_PIN_OVR,
    chan_power_down: 8'h00, low_power: 1'b0, channel_write_ok: 1'b0,
    mode_sel: 1'b0, receiver_detect_sel: 1'b0, master_reset: 1'b0};

  scfg_state_s q, n;
  logic scl_rise, scl_fall, bus_start, bus_stop, wr_en;
  logic [3:0] strap;
  logic [7:0] rd_byte;

  // Synchronised pin fields: strap in 6:3, reset pin 2, mode 1, detect 0.
  assign strap = q.pin2[6:3];
  assign scl_rise = q.scl2 & ~q.scl3;
  assign scl_fall = ~q.scl2 & q.scl3;
  assign bus_start = q.scl2 & q.scl3 & q.sda3 & ~q.sda2;
  assign bus_stop = q.scl2 & q.scl3 & ~q.sda3 & q.sda2;
  assign wr_en = (q.state == ST_WDATA) && scl_fall && (q.cnt == BITS_PER_BYTE);

  // Returns the byte seen by a read of the given index; unmapped reads zero.
  function automatic logic [7:0] rd(input scfg_state_s s, input logic [7:0] idx);
    logic [7:0] v;
    v = 8'h00;
    case (idx)
      OFS_OBSERVE: v = (s.obs & MASK_OBSERVE_RW) | {1'b0, s.pin2[6:3], config_load_done, 2'b00};
      OFS_PWDN: v = s.pwdn;
      OFS_RST_OVR: v = s.rst_ovr;
      OFS_CHECK: v = s.check;
      OFS_ACCESS: v = s.access;
      OFS_SOFT_RST: v = s.soft_rst & MASK_SOFT_RST_RW;
      OFS_PIN_OVR: v = s.pin_ovr;
      default: v = 8'h00;
    endcase
    return v;
  endfunction

  // Byte that a read of the current index would return, loaded at the start of a data phase.
  assign rd_byte = rd(q, q.index);

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic for pins, protocol engine, registers and outputs.
  always_comb
  begin
    n = q;
    n.scl1 = scl;
    n.scl2 = q.scl1;
    n.scl3 = q.scl2;
    n.sda1 = sda_in;
    n.sda2 = q.sda1;
    n.sda3 = q.sda2;
    n.pin1 = {strap_addr, reset_pin_n, mode_pin, receiver_detect_pin};
    n.pin2 = q.pin1;
    n.master_reset = 1'b0;
    n.sda_out = 1'b0;
    if (bus_stop)
    begin
      n.state = ST_IDLE;
      n.sda_oe = 1'b0;
    end
    else if (bus_start)
    begin
      n.state = ST_ADDR;
      n.cnt = 4'h0;
      n.sda_oe = 1'b0;
    end
    else
    begin
      case (q.state)
        ST_ADDR, ST_INDEX, ST_WDATA:
        begin
          if (scl_rise)
          begin
            n.sh = {q.sh[6:0], q.sda2};
            n.cnt = q.cnt + 4'h1;
          end
          else if (scl_fall && q.cnt == BITS_PER_BYTE)
          begin
            n.cnt = 4'h0;
            n.sda_oe = 1'b1;
            if (q.state == ST_ADDR)
            begin
              n.rw = q.sh[0];
              if (q.sh[7:1] == SLAVE_ADDR_BASE + {2'b00, strap, 1'b0} / 7'h2)
                n.state = ST_ACK_ADDR;
              else
              begin
                n.state = ST_IDLE;
                n.sda_oe = 1'b0;
              end
            end
            else if (q.state == ST_INDEX)
            begin
              n.index = q.sh;
              n.state = ST_ACK_INDEX;
            end
            else
              n.state = ST_ACK_WDATA;
          end
        end
        ST_ACK_ADDR, ST_ACK_INDEX, ST_ACK_WDATA:
        begin
          if (scl_fall)
          begin
            n.sda_oe = 1'b0;
            n.state = ST_WDATA;
            if (q.state == ST_ACK_ADDR && q.rw)
            begin
              n.sh = rd_byte;
              n.sda_oe = ~rd_byte[7];
              n.state = ST_RDATA;
            end
            else if (q.state == ST_ACK_ADDR)
              n.state = ST_INDEX;
          end
        end
        ST_RDATA:
        begin
          if (scl_fall)
          begin
            n.cnt = q.cnt + 4'h1;
            n.sh = {q.sh[6:0], 1'b0};
            n.sda_oe = ~q.sh[6];
            if (q.cnt == BITS_PER_BYTE - 4'h1)
            begin
              n.sda_oe = 1'b0;
              n.state = ST_MACK;
            end
          end
        end
        ST_MACK:
        begin
          if (scl_rise)
            n.mack = q.sda2;
          else if (scl_fall)
          begin
            n.cnt = 4'h0;
            n.state = ST_IDLE;
            if (!q.mack)
            begin
              n.sh = rd_byte;
              n.sda_oe = ~rd_byte[7];
              n.state = ST_RDATA;
            end
          end
        end
        default: n.state = ST_IDLE;
      endcase
    end
    // Register writes; a register reset overrides the byte being written.
    if (wr_en)
    begin
      case (q.index)
        OFS_OBSERVE: n.obs = q.sh & MASK_OBSERVE_RW;
        OFS_PWDN: n.pwdn = q.sh;
        OFS_RST_OVR: n.rst_ovr = q.sh;
        OFS_CHECK: n.check = q.sh;
        OFS_ACCESS: n.access = q.sh;
        OFS_SOFT_RST: n.soft_rst = q.sh & MASK_SOFT_RST_RW;
        OFS_PIN_OVR: n.pin_ovr = q.sh;
        default: n.index = q.index;
      endcase
      if (q.index == OFS_SOFT_RST && q.sh[BIT_MST_RESET])
        n.master_reset = 1'b1;
      if (q.index == OFS_SOFT_RST && q.sh[BIT_REG_RESET])
      begin
        n.obs = DEF_OBSERVE;
        n.pwdn = DEF_PWDN;
        n.rst_ovr = DEF_RST_OVR;
        n.check = DEF_CHECK;
        n.access = DEF_ACCESS;
        n.soft_rst = DEF_SOFT_RST;
        n.pin_ovr = DEF_PIN_OVR;
      end
    end
    // Control outputs from the current register and pin state.
    if (q.rst_ovr[BIT_RST_OVR] || q.pin2[2])
      n.chan_power_down = q.pwdn;
    else
      n.chan_power_down = ALL_POWERED_DOWN;
    n.low_power = (n.chan_power_down == ALL_POWERED_DOWN);
    n.channel_write_ok = q.access[BIT_NO_CHECK] || (q.check == check_expected);
    n.mode_sel = q.pin_ovr[BIT_MODE_OVR] ? mode_reg_value : q.pin2[1];
    n.receiver_detect_sel = q.pin_ovr[BIT_RECEIVER_DETECT_OVR] ? receiver_detect_reg_value : q.pin2[0];
  end

  // State register.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      q <= RESET_STATE;
    else
      q <= n;
  end

  assign sda_out = q.sda_out;
  assign sda_oe = q.sda_oe;
  assign chan_power_down = q.chan_power_down;
  assign low_power = q.low_power;
  assign channel_write_ok = q.channel_write_ok;
  assign mode_sel = q.mode_sel;
  assign receiver_detect_sel = q.receiver_detect_sel;
  assign master_reset = q.master_reset;

  ////////////////////////////////////////////////////////////////////////////
  // Checks beside the logic.
  property p_ack_addr;
    @(posedge clk) disable iff (!rst_n) q.state == ST_ACK_ADDR |-> sda_oe;
  endproperty
  a_ack_addr: assert property (p_ack_addr) else $error("address ack not driven");
  property p_ack_index;
    @(posedge clk) disable iff (!rst_n)
      (q.state == ST_INDEX && scl_fall && q.cnt == BITS_PER_BYTE) |=> sda_oe && q.index == $past(q.sh);
  endproperty
  a_ack_index: assert property (p_ack_index) else $error("index not taken or acked");
  property p_read_bit;
    @(posedge clk) disable iff (!rst_n) q.state == ST_RDATA |-> sda_oe == ~q.sh[7];
  endproperty
  a_read_bit: assert property (p_read_bit) else $error("read data bit wrong");
  property p_strap_read;
    @(posedge clk) disable iff (!rst_n)
      (q.state == ST_ACK_ADDR && q.rw && scl_fall && q.index == OFS_OBSERVE)
      |=> q.sh[6:3] == $past(strap) && q.sh[2] == $past(config_load_done);
  endproperty
  a_strap_read: assert property (p_strap_read) else $error("observation byte wrong");
  property p_pin_reset;
    @(posedge clk) disable iff (!rst_n)
      (!q.rst_ovr[BIT_RST_OVR] && !q.pin2[2]) |=> chan_power_down == 8'hFF ##0 low_power;
  endproperty
  a_pin_reset: assert property (p_pin_reset) else $error("reset pin not obeyed");
  property p_override;
    @(posedge clk) disable iff (!rst_n)
      q.rst_ovr[BIT_RST_OVR] |=> chan_power_down == $past(q.pwdn);
  endproperty
  a_override: assert property (p_override) else $error("power-down override lost");
  property p_no_check;
    @(posedge clk) disable iff (!rst_n) q.access[BIT_NO_CHECK] |=> channel_write_ok;
  endproperty
  a_no_check: assert property (p_no_check) else $error("write gate closed");
  property p_reg_reset;
    @(posedge clk) disable iff (!rst_n)
      (wr_en && q.index == OFS_SOFT_RST && q.sh[BIT_REG_RESET])
      |=> q.pwdn == 8'h00 && q.access == 8'h10 && q.soft_rst == 8'h01;
  endproperty
  a_reg_reset: assert property (p_reg_reset) else $error("register reset failed");
  property p_mst_reset;
    @(posedge clk) disable iff (!rst_n)
      (wr_en && q.index == OFS_SOFT_RST && q.sh[BIT_MST_RESET]) |=> master_reset ##1 !master_reset;
  endproperty
  a_mst_reset: assert property (p_mst_reset) else $error("master reset pulse wrong");
  property p_mode;
    @(posedge clk) disable iff (!rst_n)
      q.pin_ovr[BIT_MODE_OVR] |=> mode_sel == $past(mode_reg_value);
  endproperty
  a_mode: assert property (p_mode) else $error("mode override lost");
  c_read: cover property (@(posedge clk) disable iff (!rst_n) q.state == ST_MACK ##[1:40] bus_stop);
  c_write: cover property (@(posedge clk) disable iff (!rst_n) wr_en);
  c_nomatch: cover property (@(posedge clk) disable iff (!rst_n)
    q.state == ST_ADDR ##1 q.state == ST_IDLE);
endmodule
`default_nettype wire

// *** smbus_slave_config_registers_test.sv ***
`timescale 1ns/1ns
`default_nettype none
module smbus_slave_config_registers_test
  import scfg_pkg::*;
;
  logic clk, rst_n, scl, sda_low, sda_out, sda_oe, sda_wire;
  logic reset_pin_n, mode_pin, receiver_detect_pin, config_load_done;
  logic mode_reg_value, receiver_detect_reg_value, low_power, channel_write_ok;
  logic mode_sel, receiver_detect_sel, master_reset;
  logic [3:0] strap_addr;
  logic [7:0] check_expected, chan_power_down, dev_addr, rx;
  logic ack;
  int fails = 0;
  int checks_done = 0;
  int pulses = 0;
  logic [7:0] ofs_tbl [6] = '{OFS_PWDN, OFS_RST_OVR, OFS_CHECK, OFS_ACCESS, OFS_SOFT_RST,
    OFS_PIN_OVR};
  logic [7:0] def_tbl [6] = '{DEF_PWDN, DEF_RST_OVR, DEF_CHECK, DEF_ACCESS, DEF_SOFT_RST,
    DEF_PIN_OVR};

  ////////////////////////////////////////
  // Open-drain wire with pull-up; the address byte follows the straps.
  assign sda_wire = ~(sda_low | sda_oe);
  assign dev_addr = 8'hB0 + {3'h0, strap_addr, 1'b0};

  // Clock and the count of master reset pulses.
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk)
    if (master_reset === 1'b1)
      pulses <= pulses + 1;

  scfg_host i_host (.clk(clk), .sda(sda_wire), .scl(scl), .sda_low(sda_low));

  scfg_regs i_dut (.clk(clk), .rst_n(rst_n), .scl(scl), .sda_in(sda_wire),
    .sda_out(sda_out), .sda_oe(sda_oe), .strap_addr(strap_addr),
    .reset_pin_n(reset_pin_n), .mode_pin(mode_pin),
    .receiver_detect_pin(receiver_detect_pin), .config_load_done(config_load_done),
    .check_expected(check_expected), .mode_reg_value(mode_reg_value),
    .receiver_detect_reg_value(receiver_detect_reg_value),
    .chan_power_down(chan_power_down), .low_power(low_power),
    .channel_write_ok(channel_write_ok), .mode_sel(mode_sel),
    .receiver_detect_sel(receiver_detect_sel), .master_reset(master_reset));

  ////////////////////////////////////////
  // Compares and closing report.
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic end_of_test;
    $display("Checks %0d errors %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Register write and register read with all acknowledges checked.
  task automatic write_reg(input logic [7:0] idx, input logic [7:0] data);
    logic [2:0] a;
    i_host.start;
    i_host.xfer(dev_addr, rx, a[2]);
    i_host.xfer(idx, rx, a[1]);
    i_host.xfer(data, rx, a[0]);
    i_host.stop;
    check("write acks", {5'h00, a}, 8'h00);
  endtask

  task automatic expect_reg(input logic [7:0] idx, input logic [7:0] exp);
    logic [3:0] a;
    logic [7:0] d;
    i_host.start;
    i_host.xfer(dev_addr, rx, a[3]);
    i_host.xfer(idx, rx, a[2]);
    i_host.start;
    i_host.xfer(dev_addr | 8'h01, rx, a[1]);
    i_host.xfer(8'hFF, d, a[0]);
    i_host.stop;
    check("read acks", {4'h0, a}, 8'h01);
    check("register", d, exp);
  endtask

  task automatic check_defaults;
    expect_reg(OFS_OBSERVE, {1'b0, strap_addr, config_load_done, 2'b00});
    for (int i = 0; i < 6; i++)
      expect_reg(ofs_tbl[i], def_tbl[i]);
  endtask

  ////////////////////////////////////////
  // Hang guard.
  initial
  begin
    #1000000;
    fails++;
    end_of_test;
  end

  // Main sequence.
  initial
  begin
    rst_n = 1'b0;
    strap_addr = 4'h5;
    reset_pin_n = 1'b1;
    mode_pin = 1'b1;
    receiver_detect_pin = 1'b1;
    config_load_done = 1'b1;
    check_expected = 8'h5A;
    mode_reg_value = 1'b0;
    receiver_detect_reg_value = 1'b0;
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    repeat (10) @(negedge clk);
    check_defaults;
    strap_addr = 4'hA;
    config_load_done = 1'b0;
    repeat (5) @(negedge clk);
    expect_reg(OFS_OBSERVE, 8'h50);
    i_host.start;
    i_host.xfer(dev_addr ^ 8'h02, rx, ack);
    i_host.stop;
    check("foreign address ack", {7'h00, ack}, 8'h01);
    expect_reg(8'h03, 8'h00);
    write_reg(OFS_OBSERVE, 8'hFF);
    expect_reg(OFS_OBSERVE, 8'hD3);
    write_reg(OFS_PWDN, ALL_POWERED_DOWN);
    check("power down", chan_power_down, 8'hFF);
    check("low power", {7'h00, low_power}, 8'h01);
    write_reg(OFS_PWDN, 8'h5A);
    check("low power", {7'h00, low_power}, 8'h00);
    reset_pin_n = 1'b0;
    repeat (5) @(negedge clk);
    check("pin power down", chan_power_down, 8'hFF);
    write_reg(OFS_RST_OVR, 8'h01);
    check("override power down", chan_power_down, 8'h5A);
    reset_pin_n = 1'b1;
    check("write ok", {7'h00, channel_write_ok}, 8'h00);
    write_reg(OFS_CHECK, 8'h5A);
    check("write ok", {7'h00, channel_write_ok}, 8'h01);
    write_reg(OFS_CHECK, 8'h00);
    check("write ok", {7'h00, channel_write_ok}, 8'h00);
    write_reg(OFS_ACCESS, 8'h18);
    check("write ok", {7'h00, channel_write_ok}, 8'h01);
    check("mode pin", {6'h00, mode_sel, receiver_detect_sel}, 8'h03);
    write_reg(OFS_PIN_OVR, 8'h0C);
    check("mode reg", {6'h00, mode_sel, receiver_detect_sel}, 8'h00);
    write_reg(OFS_SOFT_RST, 8'h21);
    check("master pulses", pulses[7:0], 8'h01);
    expect_reg(OFS_SOFT_RST, 8'h01);
    write_reg(OFS_SOFT_RST, 8'h41);
    check_defaults;
    check("default power", chan_power_down, 8'h00);
    check("default mode", {6'h00, mode_sel, receiver_detect_sel}, 8'h03);
    check("sda out", {7'h00, sda_out}, 8'h00);
    end_of_test;
  end
endmodule
`default_nettype wire
